// ==== hdl/dpcm_pkg.sv ====
// shared types, mode tables and decode helpers for the 12-bit pixel compressor
package dpcm_pkg;

   // pixel and word geometry
   localparam int         PIX_W      = 12;                  // raw pixel width
   localparam int         WORD_W     = 8;                   // widest encoded word
   localparam int         NUM_MODES  = 6;                   // difference modes per scheme
   localparam int         MODE_W     = 3;                   // width of a mode index
   localparam logic [3:0] PIX_W_L    = 4'hC;                // pixel width as a shift operand
   localparam logic [3:0] ONE_BIT    = 4'h1;                // width taken by the leading plain bit
   localparam logic       PLAIN_LEAD = 1'b1;                // leading bit of a plain-value word
   localparam logic [7:0] START_MIN  = 8'h01;               // replaces an all-zero line-start word

   // compression scheme selection, static while pixels flow
   typedef enum logic [1:0] {
      SCHEME_12_8 = 2'h0,                                   // 8-bit words
      SCHEME_12_7 = 2'h1,                                   // 7-bit words
      SCHEME_12_6 = 2'h3                                    // 6-bit words
   } scheme_t;

   // one difference mode: range limit, offset, shift, code word and its length
   typedef struct packed {
      logic [11:0] limit;                                   // absolute difference must be below this
      logic [11:0] offset;                                  // subtracted before scaling
      logic [2:0]  shift;                                   // log2 of the divisor
      logic [3:0]  code;                                    // code word, right aligned
      logic [2:0]  code_len;                                // code word length in bits
   } mode_entry_t;

   // pixel arriving from the source
   typedef struct packed {
      logic [11:0] pixel;                                   // original pixel
      logic [11:0] pred;                                    // predicted value
      logic        no_pred;                                 // line start, no prediction
   } pixel_in_t;

   // encoded word leaving for the packer
   typedef struct packed {
      logic [7:0]  word;                                    // code word in the top bits of the scheme width
      logic [2:0]  mode;                                    // difference mode used, zero based
      logic        plain;                                   // plain-value or line-start word
   } enc_out_t;

   // mode tables, rows 12-8, 12-7, 12-6; 12-8 pads its sixth mode with an unreachable copy
   localparam mode_entry_t MODE_TABLE [3][NUM_MODES] = '{
      '{'{12'h008, 12'h000, 3'h0, 4'h0, 3'h4}, '{12'h028, 12'h008, 3'h1, 4'h3, 3'h3},
        '{12'h068, 12'h028, 3'h2, 4'h2, 3'h3}, '{12'h0E8, 12'h068, 3'h3, 4'h1, 3'h3},
        '{12'h168, 12'h0E8, 3'h4, 4'h1, 3'h4}, '{12'h168, 12'h0E8, 3'h4, 4'h1, 3'h4}},
      '{'{12'h004, 12'h000, 3'h0, 4'h0, 3'h4}, '{12'h00C, 12'h004, 3'h1, 4'h1, 3'h4},
        '{12'h01C, 12'h00C, 3'h2, 4'h2, 3'h4}, '{12'h05C, 12'h01C, 3'h3, 4'h2, 3'h3},
        '{12'h0DC, 12'h05C, 3'h4, 4'h3, 3'h3}, '{12'h15C, 12'h0DC, 3'h5, 4'h3, 3'h4}},
      '{'{12'h002, 12'h000, 3'h0, 4'h0, 3'h4}, '{12'h00A, 12'h002, 3'h2, 4'h1, 3'h4},
        '{12'h02A, 12'h00A, 3'h3, 4'h2, 3'h3}, '{12'h04A, 12'h02A, 3'h4, 4'h2, 3'h4},
        '{12'h0CA, 12'h04A, 3'h5, 4'h3, 3'h3}, '{12'h14A, 12'h0CA, 3'h6, 4'h3, 3'h4}}
   };

   // word width of each scheme
   localparam logic [3:0] SCHEME_WIDTH [3] = '{4'h8, 4'h7, 4'h6};

   // table row of a scheme; the unused code falls back to 12-8
   function automatic logic [1:0] scheme_row(input scheme_t s);
      unique case (s)
         SCHEME_12_7: scheme_row = 2'h1;
         SCHEME_12_6: scheme_row = 2'h2;
         default:     scheme_row = 2'h0;
      endcase
   endfunction : scheme_row

   // one mode entry of a scheme
   function automatic mode_entry_t mode_entry(input scheme_t s, input int idx);
      mode_entry = MODE_TABLE[scheme_row(s)][idx];
   endfunction : mode_entry

   // word width of a scheme
   function automatic logic [3:0] scheme_width(input scheme_t s);
      scheme_width = SCHEME_WIDTH[scheme_row(s)];
   endfunction : scheme_width

endpackage : dpcm_pkg

// ==== hdl/pixel_diff.sv ====
// difference of original and predicted pixel, with magnitude and sign flags
`timescale 1ns/1ns
`default_nettype none
module pixel_diff
   import dpcm_pkg::*;
(
   // operands
   input  wire logic [11:0] pixel,
   input  wire logic [11:0] pred,
   // results
   output logic [11:0]      abs_diff,
   output logic             neg,
   output logic             non_pos
);

   logic signed [12:0] diff;                                // original minus prediction

   // signed difference and its magnitude
   always_comb begin
      diff     = $signed({1'b0, pixel}) - $signed({1'b0, pred});
      neg      = diff[12];
      non_pos  = diff[12] || (diff == 13'h0000);
      abs_diff = neg ? 12'(-diff) : diff[11:0];
   end

endmodule : pixel_diff
`default_nettype wire

// ==== hdl/range_selector.sv ====
// picks the first difference mode whose range holds the magnitude
`timescale 1ns/1ns
`default_nettype none
module range_selector
   import dpcm_pkg::*;
(
   // inputs
   input  wire scheme_t     scheme,
   input  wire logic [11:0] abs_diff,
   // selection
   output logic [2:0]       mode,
   output logic             plain
);

   logic [NUM_MODES-1:0] below;                             // magnitude under each mode limit

   // one comparator per mode
   genvar gi;
   generate
      for (gi = 0; gi < NUM_MODES; gi++) begin : g_cmp
         assign below[gi] = abs_diff < MODE_TABLE[scheme_row(scheme)][gi].limit;
      end
   endgenerate

   // lowest matching mode wins; none matching means plain value
   always_comb begin
      mode  = 3'h0;
      plain = 1'b1;
      for (int i = NUM_MODES - 1; i >= 0; i--) begin
         if (below[i]) begin
            mode  = 3'(i);
            plain = 1'b0;
         end
      end
   end

endmodule : range_selector
`default_nettype wire

// ==== hdl/pixel_dpcm_compressor_12bit.sv ====
// 12-bit pixel compressor: line-start, difference and plain-value encoding
`timescale 1ns/1ns
`default_nettype none
// Function
// - 12-8 mode four: 001, sign, (abs-104)/8
// - 12-8 mode five: 0001, sign, (abs-232)/16
// - 12-8 plain: leading 1, pixel/32
// - 12-7 line start: pixel/32, zero becomes 1
// - 12-7 ranges 4,12,28,92,220,348 else plain
// - 12-7 mode one: 0000, sign on <=0, abs
// - 12-7 mode two: 0001, sign, (abs-4)/2
// - 12-7 mode three: 0010, sign, (abs-12)/4
// - 12-7 mode four: 010, sign, (abs-28)/8
// - 12-7 mode five: 011, sign, (abs-92)/16
// - 12-7 mode six: 0011, sign, (abs-220)/32
// - 12-7 plain: leading 1, pixel/64
// - later modes: sign set only when negative
// - 12-6 line start: pixel/64, zero becomes 1
// - 12-6 ranges 2,10,42,74,202,330, skip two
// - 12-6 mode one: 0000, sign on <=0, abs
// - 12-6 mode three: 0001, sign, (abs-2)/4
// - 12-6 mode four: 010, sign, (abs-10)/8
// - 12-6 mode five: 0010, sign, (abs-42)/16
// - 12-6 mode six: 011, sign, (abs-74)/32
// - 12-6 mode seven: 0011, sign, (abs-202)/64
// - 12-6 plain: leading 1, five-bit field
// - 12-6 plain field is pixel/128
module pixel_dpcm_compressor_12bit
   import dpcm_pkg::*;
(
   // clock and reset
   input  wire logic      clk,
   input  wire logic      resetn,
   // pixel source
   input  wire logic      in_valid,
   input  wire pixel_in_t in_pix,
   input  wire scheme_t   in_scheme,
   // packer side
   output logic           out_valid,
   output enc_out_t       out_enc
);

   // combinational encode path
   logic [11:0] abs_diff;                                   // magnitude of the difference
   logic        neg;                                        // difference below zero
   logic        non_pos;                                    // difference zero or below
   logic [2:0]  sel_mode;                                   // chosen difference mode
   logic        sel_plain;                                  // range exceeded, send plain value
   enc_out_t    enc_next;                                   // word to register
   // output registers
   logic        out_valid_reg;                              // word present this cycle
   enc_out_t    out_enc_reg;                                // encoded word

   // difference of original and prediction
   pixel_diff u_diff (
      .pixel    (in_pix.pixel),
      .pred     (in_pix.pred),
      .abs_diff (abs_diff),
      .neg      (neg),
      .non_pos  (non_pos)
   );

   // range comparison across the scheme's modes
   range_selector u_range (
      .scheme   (in_scheme),
      .abs_diff (abs_diff),
      .mode     (sel_mode),
      .plain    (sel_plain)
   );

   // difference word: code on top, sign, then scaled magnitude
   function automatic logic [7:0] pack_diff(input scheme_t s, input mode_entry_t e,
                                            input logic sgn, input logic [11:0] a);
      logic [3:0]  w;
      logic [3:0]  vbits;
      logic [11:0] v;
      logic [7:0]  word;
      w     = scheme_width(s);
      vbits = w - ONE_BIT - {1'b0, e.code_len};
      v     = (a - e.offset) >> e.shift;                    // truncating divide
      word  = 8'(e.code) << (w - {1'b0, e.code_len});       // code word in the top bits
      word  = word | (8'(sgn) << vbits);
      word  = word | (8'(v) & ((8'h01 << vbits) - 8'h01));
      return word;
   endfunction : pack_diff

   // plain-value word: leading one then pixel scaled to width minus one
   function automatic logic [7:0] pack_plain(input scheme_t s, input logic [11:0] px);
      logic [3:0] w;
      w = scheme_width(s);
      return (8'(PLAIN_LEAD) << (w - ONE_BIT)) | 8'(px >> (PIX_W_L - w + ONE_BIT));
   endfunction : pack_plain

   // line-start word: pixel scaled to the full width, never all zero
   function automatic logic [7:0] pack_start(input scheme_t s, input logic [11:0] px);
      logic [7:0] v;
      v = 8'(px >> (PIX_W_L - scheme_width(s)));
      return (v == 8'h00) ? START_MIN : v;                  // zero replaced
   endfunction : pack_start

   // choose the word for this pixel
   always_comb begin
      enc_next = '0;
      if (in_pix.no_pred) begin
         // no prediction at line start
         enc_next.word  = pack_start(in_scheme, in_pix.pixel);
         enc_next.plain = 1'b1;
      end else if (sel_plain) begin
         // magnitude beyond the last range
         enc_next.word  = pack_plain(in_scheme, in_pix.pixel);
         enc_next.plain = 1'b1;
      end else begin
         // first mode signs zero as negative, others only on negative
         enc_next.word = pack_diff(in_scheme, mode_entry(in_scheme, int'(sel_mode)),
                                   (sel_mode == 3'h0) ? non_pos : neg, abs_diff);
         enc_next.mode = sel_mode;
      end
   end

   // word valid flag follows the source one cycle later
   always_ff @(posedge clk) begin
      if (!resetn) begin
         out_valid_reg <= 1'b0;
      end else begin
         out_valid_reg <= in_valid;
      end
   end

   // encoded word register, loaded with each incoming pixel
   always_ff @(posedge clk) begin
      if (!resetn) begin
         out_enc_reg <= '0;
      end else if (in_valid) begin
         out_enc_reg <= enc_next;
      end
   end

   // ports straight from the registers
   assign out_valid = out_valid_reg;
   assign out_enc   = out_enc_reg;

   // checks: a predicted pixel of a scheme with magnitude in a range
   sequence s_pred(scheme_t s, int lo, int hi);
      in_valid && (in_scheme == s) && !in_pix.no_pred && (abs_diff >= lo) && (abs_diff < hi);
   endsequence

   // checks: a line-start pixel of a scheme
   sequence s_start(scheme_t s);
      in_valid && (in_scheme == s) && in_pix.no_pred;
   endsequence

   // 12-8 mode four
   chk_mode4_w8: assert property (@(posedge clk) disable iff (!resetn)
      s_pred(SCHEME_12_8, 12'h068, 12'h0E8) |=> (out_enc_reg.word[7:5] == 3'h1)
         && (out_enc_reg.word[4] == $past(neg))
         && (out_enc_reg.word[3:0] == 4'(($past(abs_diff) - 12'h068) >> 3)))
      else $error("12-8 mode four word wrong");

   // 12-8 mode five
   chk_mode5_w8: assert property (@(posedge clk) disable iff (!resetn)
      s_pred(SCHEME_12_8, 12'h0E8, 12'h168) |=> (out_enc_reg.word[7:4] == 4'h1)
         && (out_enc_reg.word[3] == $past(neg))
         && (out_enc_reg.word[2:0] == 3'(($past(abs_diff) - 12'h0E8) >> 4)))
      else $error("12-8 mode five word wrong");

   // 12-8 plain value
   chk_plain_w8: assert property (@(posedge clk) disable iff (!resetn)
      s_pred(SCHEME_12_8, 12'h168, 12'hFFF) ##0 (abs_diff != 12'hFFF) |=> out_enc_reg.plain
         && (out_enc_reg.word == {1'b1, $past(in_pix.pixel[11:5])}))
      else $error("12-8 plain word wrong");

   // 12-7 line start
   chk_start_w7: assert property (@(posedge clk) disable iff (!resetn)
      s_start(SCHEME_12_7) |=> (out_enc_reg.word[7] == 1'b0) && (out_enc_reg.word != 8'h00)
         && (($past(in_pix.pixel[11:5]) == 7'h00) || (out_enc_reg.word[6:0] == $past(in_pix.pixel[11:5]))))
      else $error("12-7 line start word wrong");

   // 12-7 top range picks mode six
   chk_range_w7: assert property (@(posedge clk) disable iff (!resetn)
      s_pred(SCHEME_12_7, 12'h0DC, 12'h15C) |=> (out_enc_reg.mode == 3'h5) && !out_enc_reg.plain)
      else $error("12-7 mode six not chosen");

   // 12-7 mode one, zero sent as negative
   chk_mode1_w7: assert property (@(posedge clk) disable iff (!resetn)
      s_pred(SCHEME_12_7, 12'h000, 12'h004) |=> (out_enc_reg.word[6:3] == 4'h0)
         && (out_enc_reg.word[2] == $past(non_pos)) && (out_enc_reg.word[1:0] == $past(abs_diff[1:0])))
      else $error("12-7 mode one word wrong");

   // 12-7 mode two
   chk_mode2_w7: assert property (@(posedge clk) disable iff (!resetn)
      s_pred(SCHEME_12_7, 12'h004, 12'h00C) |=> (out_enc_reg.word[6:3] == 4'h1)
         && (out_enc_reg.word[1:0] == 2'(($past(abs_diff) - 12'h004) >> 1)))
      else $error("12-7 mode two word wrong");

   // 12-7 mode three
   chk_mode3_w7: assert property (@(posedge clk) disable iff (!resetn)
      s_pred(SCHEME_12_7, 12'h00C, 12'h01C) |=> (out_enc_reg.word[6:3] == 4'h2)
         && (out_enc_reg.word[1:0] == 2'(($past(abs_diff) - 12'h00C) >> 2)))
      else $error("12-7 mode three word wrong");

   // 12-7 mode four
   chk_mode4_w7: assert property (@(posedge clk) disable iff (!resetn)
      s_pred(SCHEME_12_7, 12'h01C, 12'h05C) |=> (out_enc_reg.word[6:4] == 3'h2)
         && (out_enc_reg.word[2:0] == 3'(($past(abs_diff) - 12'h01C) >> 3)))
      else $error("12-7 mode four word wrong");

   // 12-7 mode five
   chk_mode5_w7: assert property (@(posedge clk) disable iff (!resetn)
      s_pred(SCHEME_12_7, 12'h05C, 12'h0DC) |=> (out_enc_reg.word[6:4] == 3'h3)
         && (out_enc_reg.word[2:0] == 3'(($past(abs_diff) - 12'h05C) >> 4)))
      else $error("12-7 mode five word wrong");

   // 12-7 mode six
   chk_mode6_w7: assert property (@(posedge clk) disable iff (!resetn)
      s_pred(SCHEME_12_7, 12'h0DC, 12'h15C) |=> (out_enc_reg.word[6:3] == 4'h3)
         && (out_enc_reg.word[1:0] == 2'(($past(abs_diff) - 12'h0DC) >> 5)))
      else $error("12-7 mode six word wrong");

   // 12-7 plain value
   chk_plain_w7: assert property (@(posedge clk) disable iff (!resetn)
      in_valid && (in_scheme == SCHEME_12_7) && !in_pix.no_pred && (abs_diff >= 12'h15C)
         |=> (out_enc_reg.word == {2'b01, $past(in_pix.pixel[11:6])}))
      else $error("12-7 plain word wrong");

   // zero difference in a later mode is positive; a negative one sets the sign
   chk_sign_rule: assert property (@(posedge clk) disable iff (!resetn)
      s_pred(SCHEME_12_7, 12'h004, 12'h01C) |=> (out_enc_reg.word[2] == $past(neg)))
      else $error("sign bit wrong outside mode one");

   // 12-6 line start
   chk_start_w6: assert property (@(posedge clk) disable iff (!resetn)
      s_start(SCHEME_12_6) |=> (out_enc_reg.word[7:6] == 2'h0) && (out_enc_reg.word != 8'h00)
         && (($past(in_pix.pixel[11:6]) == 6'h00) || (out_enc_reg.word[5:0] == $past(in_pix.pixel[11:6]))))
      else $error("12-6 line start word wrong");

   // 12-6 mode one and mode three words
   chk_low_w6: assert property (@(posedge clk) disable iff (!resetn)
      s_pred(SCHEME_12_6, 12'h000, 12'h00A) |=> (out_enc_reg.word[5:3] == 3'h0)
         && (out_enc_reg.word[2] == ($past(abs_diff) >= 12'h002))
         && (out_enc_reg.word[1] == ($past(abs_diff) < 12'h002 ? $past(non_pos) : $past(neg)))
         && (out_enc_reg.word[0] == ($past(abs_diff) < 12'h002 ? $past(abs_diff[0])
                                                              : 1'(($past(abs_diff) - 12'h002) >> 2))))
      else $error("12-6 low mode word wrong");

   // 12-6 modes four and five
   chk_mid_w6: assert property (@(posedge clk) disable iff (!resetn)
      s_pred(SCHEME_12_6, 12'h00A, 12'h04A) |=> ($past(abs_diff) < 12'h02A)
         ? (out_enc_reg.word[5:3] == 3'h2) && (out_enc_reg.word[1:0] == 2'(($past(abs_diff) - 12'h00A) >> 3))
         : (out_enc_reg.word[5:2] == 4'h2) && (out_enc_reg.word[0] == 1'(($past(abs_diff) - 12'h02A) >> 4)))
      else $error("12-6 middle mode word wrong");

   // 12-6 modes six and seven
   chk_high_w6: assert property (@(posedge clk) disable iff (!resetn)
      s_pred(SCHEME_12_6, 12'h04A, 12'h14A) |=> ($past(abs_diff) < 12'h0CA)
         ? (out_enc_reg.word[5:3] == 3'h3) && (out_enc_reg.word[1:0] == 2'(($past(abs_diff) - 12'h04A) >> 5))
         : (out_enc_reg.word[5:2] == 4'h3) && (out_enc_reg.word[0] == 1'(($past(abs_diff) - 12'h0CA) >> 6)))
      else $error("12-6 high mode word wrong");

   // 12-6 plain value
   chk_plain_w6: assert property (@(posedge clk) disable iff (!resetn)
      in_valid && (in_scheme == SCHEME_12_6) && !in_pix.no_pred && (abs_diff >= 12'h14A)
         |=> (out_enc_reg.word == {3'b001, $past(in_pix.pixel[11:7])}))
      else $error("12-6 plain word wrong");

   // 12-7 all-zero line start sends one
   chk_zero_w7: assert property (@(posedge clk) disable iff (!resetn)
      s_start(SCHEME_12_7) ##0 (in_pix.pixel[11:5] == 7'h00) |=> (out_enc_reg.word == START_MIN))
      else $error("12-7 zero line start not one");

   // 12-6 all-zero line start sends one
   chk_zero_w6: assert property (@(posedge clk) disable iff (!resetn)
      s_start(SCHEME_12_6) ##0 (in_pix.pixel[11:6] == 6'h00) |=> (out_enc_reg.word == START_MIN))
      else $error("12-6 zero line start not one");

   // 12-6 top range picks mode seven
   chk_range_w6: assert property (@(posedge clk) disable iff (!resetn)
      s_pred(SCHEME_12_6, 12'h0CA, 12'h14A) |=> (out_enc_reg.mode == 3'h5) && !out_enc_reg.plain)
      else $error("12-6 mode seven not chosen");

   // 12-6 zero difference outside mode one is positive
   chk_sign_w6: assert property (@(posedge clk) disable iff (!resetn)
      s_pred(SCHEME_12_6, 12'h00A, 12'h02A) |=> (out_enc_reg.word[2] == $past(neg)))
      else $error("12-6 sign bit wrong outside mode one");

   // plain and line-start words carry mode zero
   chk_plain_mode: assert property (@(posedge clk) disable iff (!resetn)
      out_enc_reg.plain |-> (out_enc_reg.mode == 3'h0))
      else $error("plain word carries a mode");

   // a taken pixel raises valid next cycle
   chk_valid_set: assert property (@(posedge clk) disable iff (!resetn)
      in_valid |=> out_valid_reg)
      else $error("valid missing after a pixel");

   // no pixel, no valid next cycle
   chk_valid_clr: assert property (@(posedge clk) disable iff (!resetn)
      !in_valid |=> !out_valid_reg)
      else $error("valid without a pixel");

   // valid follows the source by one cycle
   chk_valid_lag: assert property (@(posedge clk) disable iff (!resetn)
      in_valid ##1 !in_valid |=> !out_valid_reg ##0 $past(out_valid_reg))
      else $error("valid does not lag the source by one cycle");

endmodule : pixel_dpcm_compressor_12bit
`default_nettype wire

// ==== verif/pixel_source_model.sv ====
// pixel source and packer sink standing around the compressor
`timescale 1ns/1ns
`default_nettype none
module pixel_source_model
   import dpcm_pkg::*;
(
   // clock
   input  wire logic clk,
   // toward the compressor
   output logic      in_valid,
   output pixel_in_t in_pix,
   output scheme_t   in_scheme,
   // from the compressor
   input  wire logic out_valid
);
   int words_seen;                                     // words taken by the packer

   // quiet source at time zero
   initial begin
      in_valid   = 1'b0;
      in_pix     = '0;
      in_scheme  = SCHEME_12_8;
      words_seen = 0;
   end

   // packer never stalls, it just counts words
   always @(posedge clk) begin
      if (out_valid === 1'b1) begin
         words_seen++;
      end
   end

   // one pixel with its prediction, start flag and scheme
   task automatic put(input scheme_t s, input logic [11:0] p, input logic [11:0] pr, input logic np);
      @(negedge clk);
      in_scheme = s;
      in_valid  = 1'b1;
      in_pix    = '{pixel: p, pred: pr, no_pred: np};
   endtask : put

   // idle cycle; data lines flip so stale values are never trusted
   task automatic idle();
      @(negedge clk);
      in_valid = 1'b0;
      in_pix   = ~in_pix;
   endtask : idle
endmodule : pixel_source_model
`default_nettype wire

// ==== verif/tb.sv ====
// self-checking bench for the 12-bit pixel compressor
`timescale 1ns/1ns
`default_nettype none
module tb
   import dpcm_pkg::*;
;
   // per-scheme tables, rows 12-8, 12-7, 12-6
   localparam int LIM [3][6] = '{'{8,40,104,232,360,360}, '{4,12,28,92,220,348}, '{2,10,42,74,202,330}};
   localparam int OFF [3][6] = '{'{0,8,40,104,232,232}, '{0,4,12,28,92,220}, '{0,2,10,42,74,202}};
   localparam int SH  [3][6] = '{'{0,1,2,3,4,4}, '{0,1,2,3,4,5}, '{0,2,3,4,5,6}};
   localparam int CD  [3][6] = '{'{0,3,2,1,1,1}, '{0,1,2,2,3,3}, '{0,1,2,2,3,3}};
   localparam int CL  [3][6] = '{'{4,3,3,3,4,4}, '{4,4,4,3,3,4}, '{4,4,3,4,3,4}};
   localparam int WID [3]    = '{8, 7, 6};             // word width
   localparam int LS  [3]    = '{4, 5, 6};             // line-start divisor shift
   localparam int PS  [3]    = '{5, 6, 7};             // plain divisor shift
   localparam scheme_t SC [3] = '{SCHEME_12_8, SCHEME_12_7, SCHEME_12_6};

   logic      clk = 1'b0;                              // 100 MHz clock
   logic      resetn = 1'b0;                           // active low reset
   logic      in_valid;                                // source strobe
   pixel_in_t in_pix;                                  // source pixel
   scheme_t   in_scheme;                               // active scheme
   logic      out_valid;                               // word strobe
   enc_out_t  out_enc;                                 // encoded word
   int        fails = 0;                               // mismatches
   int        total_checks = 0;                        // comparisons
   int        sent = 0;                                // pixels handed over

   // clock generator
   always #5 clk = ~clk;

   pixel_dpcm_compressor_12bit i_pixel_dpcm_compressor_12bit (
      .clk(clk), .resetn(resetn), .in_valid(in_valid), .in_pix(in_pix),
      .in_scheme(in_scheme), .out_valid(out_valid), .out_enc(out_enc));
   pixel_source_model i_pixel_source_model (
      .clk(clk), .in_valid(in_valid), .in_pix(in_pix), .in_scheme(in_scheme), .out_valid(out_valid));

   // expected word worked out from the coder ranges
   function automatic enc_out_t exp_enc(input int r, input logic [11:0] p, input logic [11:0] pr, input logic np);
      int d;
      int a;
      int m;
      int cw;
      enc_out_t e;
      e = '0;
      d = int'(p) - int'(pr);
      a = (d < 0) ? -d : d;
      if (np) begin
         e.word  = 8'(p >> LS[r]);
         e.word  = (e.word == 8'h00) ? 8'h01 : e.word;
         e.plain = 1'b1;
         return e;
      end
      for (m = 0; m < 6; m++) if (a < LIM[r][m]) break;
      if (m == 6) begin
         e.word  = 8'((1 << (WID[r] - 1)) | (p >> PS[r]));
         e.plain = 1'b1;
      end else begin
         cw     = WID[r] - CL[r][m];
         e.word = 8'((CD[r][m] << cw) | ((m == 0 ? int'(d <= 0) : int'(d < 0)) << (cw - 1))
                     | (((a - OFF[r][m]) >> SH[r][m]) & ((1 << (cw - 1)) - 1)));
         e.mode = 3'(m);
      end
      return e;
   endfunction : exp_enc

   // compare and count
   task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   // one pixel in, one word out a cycle later
   task automatic one(input int r, input logic [11:0] p, input logic [11:0] pr, input logic np);
      enc_out_t e;
      e = exp_enc(r, p, pr, np);
      i_pixel_source_model.put(SC[r], p, pr, np);
      i_pixel_source_model.idle();
      sent++;
      cmp(12'(out_valid), 12'h001);
      cmp(out_enc, e);
   endtask : one

   // outputs quiet after reset
   task automatic t_reset_state();
      cmp(12'(out_valid), 12'h000);
      cmp(out_enc, 12'h000);
      $display("test reset_state done");
   endtask : t_reset_state

   // line starts: zero forced up, prediction ignored
   task automatic t_line_start();
      for (int r = 0; r < 3; r++) begin
         one(r, 12'h000, 12'h000, 1'b1);
         one(r, 12'h07F, 12'hFFF, 1'b1);
         one(r, 12'hFFF, 12'h000, 1'b1);
      end
      $display("test line_start done");
   endtask : t_line_start

   // both ends of every range, both signs, then plain
   task automatic t_diff_modes();
      int a;
      for (int r = 0; r < 3; r++) begin
         one(r, 12'h800, 12'h000, 1'b1);
         for (int m = 0; m < 6; m++)
            for (int k = 0; k < 2; k++)
               for (int sg = 0; sg < 2; sg++) begin
                  a = k ? LIM[r][m] - 1 : OFF[r][m];
                  one(r, 12'h800, 12'(sg ? 2048 + a : 2048 - a), 1'b0);
               end
         one(r, 12'hFFF, 12'(4095 - LIM[r][5]), 1'b0);
         one(r, 12'h000, 12'hFFF, 1'b0);
      end
      $display("test diff_modes done");
   endtask : t_diff_modes

   // two pixels back to back, then held output
   task automatic t_back_to_back();
      enc_out_t e2;
      e2 = exp_enc(1, 12'h064, 12'h0C8, 1'b0);
      i_pixel_source_model.put(SCHEME_12_7, 12'h064, 12'h05A, 1'b0);
      i_pixel_source_model.put(SCHEME_12_7, 12'h064, 12'h0C8, 1'b0);
      cmp(out_enc, exp_enc(1, 12'h064, 12'h05A, 1'b0));
      i_pixel_source_model.idle();
      cmp(out_enc, e2);
      i_pixel_source_model.idle();
      cmp(12'(out_valid), 12'h000);
      cmp(out_enc, e2);
      sent += 2;
      $display("test back_to_back done");
   endtask : t_back_to_back

   // unused scheme code behaves as 12-8
   task automatic t_spare_code();
      enc_out_t e;
      e = exp_enc(0, 12'h800, 12'h790, 1'b0);
      i_pixel_source_model.put(scheme_t'(2'h2), 12'h800, 12'h790, 1'b0);
      i_pixel_source_model.idle();
      sent++;
      cmp(12'(out_valid), 12'h001);
      cmp(out_enc, e);
      $display("test spare_code done");
   endtask : t_spare_code

   // reset in mid run clears the outputs
   task automatic t_mid_reset();
      one(2, 12'h123, 12'h100, 1'b0);
      resetn = 1'b0;
      @(negedge clk);
      cmp(12'(out_valid), 12'h000);
      cmp(out_enc, 12'h000);
      resetn = 1'b1;
      $display("test mid_reset done");
   endtask : t_mid_reset

   // one word for every pixel
   task automatic t_pairing();
      @(negedge clk);
      cmp(12'(i_pixel_source_model.words_seen), 12'(sent));
      $display("test pairing done");
   endtask : t_pairing

   // verdict and end of run
   task automatic results();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results

   // main sequence
   initial begin
      repeat (6) @(negedge clk);
      resetn = 1'b1;
      t_reset_state();
      t_line_start();
      t_diff_modes();
      t_back_to_back();
      t_spare_code();
      t_mid_reset();
      t_pairing();
      results();
   end

   // watchdog, far beyond the few hundred cycles needed
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      results();
   end
endmodule : tb
`default_nettype wire
